// >>> latency_timer.sv
// Holds the shared constants, state types and a reloadable latency timer.
// Assumes one clock and a synchronous, active-high reset.
// ----------------------------------------------------------------
// How it works
// - Long calibration runs engine, then updates I/O.
// - First long gets init window, later oper.
// - Short calibration finishes within its short window.
// - Calibration current path switched off when done.
// - No automatic recalibration on self-refresh exit.
// - Enter low-power on CKE low with NOP/DES, not while a calibration runs.
// - Leave low-power on CKE high with NOP/DES.
// ----------------------------------------------------------------

`timescale 1ns/1ns

package pdzq_pkg;
  // Clock rate
  localparam int CLK_MHZ = 100;
  // Calibration code width and the midpoint that a long calibration starts from
  localparam int CODE_W = 6;
  localparam logic [5:0] CODE_RESET = 6'h20;
  // Width of window and latency counters
  localparam int CNT_W = 10;
  // Calibration windows in clock cycles
  localparam logic [9:0] TZQINIT_CYC = 10'h200;
  localparam logic [9:0] TZQOPER_CYC = 10'h100;
  localparam logic [9:0] TZQCS_CYC = 10'h040;
  // Exit latencies as times, and their least whole-cycle counts
  localparam int TXP_NS = 24;
  localparam int TXPDLL_NS = 24;
  localparam logic [9:0] TXP_CYC = 10'((TXP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [9:0] TXPDLL_CYC = 10'((TXPDLL_NS * CLK_MHZ + 999) / 1000);

  // Power state of the device
  typedef enum logic [1:0] {ST_ACTIVE, ST_POWER_DOWN, ST_SELF_REFRESH} pwr_state_t;
  // Calibration engine state
  typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_XFER} cal_state_t;
endpackage

// ----------------------------------------------------------------
// Reloadable down counter, busy while any cycle of the latency remains
// ----------------------------------------------------------------
module latency_timer #(
  parameter int WIDTH = pdzq_pkg::CNT_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Load request and latency in cycles
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  // High while the latency runs
  output logic busyQ
);
  logic [WIDTH-1:0] cntQ; // Cycles left
  logic [WIDTH-1:0] cntD;
  logic busyD;

  // Next count: load wins over counting down
  always_comb
  begin
    cntD = cntQ;
    if (load)
    begin
      cntD = loadValue;
    end
    else if (cntQ != '0)
    begin
      cntD = cntQ - WIDTH'(1);
    end
    busyD = (cntD != '0);
  end

  // Register count and busy flag
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cntQ <= '0;
      busyQ <= 1'b0;
    end
    else
    begin
      cntQ <= cntD;
      busyQ <= busyD;
    end
  end
endmodule

// >>> power_down_zq_calibration.sv
// Power-down state tracking and calibration engine of the memory device.
// Assumes command pins and CKE are synchronous to ref_clk; the driver
// comparator result compUp is settled every cycle.
`timescale 1ns/1ns

module power_down_zq_calibration (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Command bus from the controller
  input wire logic ckeIn,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic addr10,
  // Device reset pin, active low
  input wire logic resetN,
  // Comparator against calibration_reference_resistor: high means step code up
  input wire logic compUp,
  // Power state
  output logic lowPowerQ,
  output logic selfRefreshQ,
  output logic exitBusyQ,
  output logic dllExitBusyQ,
  // Calibration status and results
  output logic calBusyQ,
  output logic calLongQ,
  output logic calCurrentEnQ,
  output logic firstLongPendingQ,
  output logic impedanceUpdateQ,
  output logic [pdzq_pkg::CODE_W-1:0] driverImpedanceQ
);
  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic ckePrevQ; // CKE sampled last cycle
  logic cmdNop; // NOP or deselect
  logic cmdRefresh; // Refresh, or self-refresh entry with CKE low
  logic cmdZq; // Either calibration command
  logic cmdValid; // Command taken while clocked in and awake
  logic calStart;
  logic exitPulse; // Low-power or self-refresh exit this cycle

  assign cmdNop = csN | (rasN & casN & weN);
  assign cmdRefresh = ~csN & ~rasN & ~casN & weN;
  assign cmdZq = ~csN & rasN & casN & ~weN;

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  pdzq_pkg::pwr_state_t pwrQ; // Current power state
  pdzq_pkg::pwr_state_t pwrD;

  // Entry is decided on the CKE fall, exit on any cycle with CKE high, each with the command beside it
  always_comb
  begin
    pwrD = pwrQ;
    exitPulse = 1'b0;
    unique case (pwrQ)
      pdzq_pkg::ST_ACTIVE:
      begin
        // Entry is not taken while a calibration runs
        if (ckePrevQ && !ckeIn && !calBusyQ)
        begin
          if (cmdNop)
          begin
            pwrD = pdzq_pkg::ST_POWER_DOWN;
          end
          else if (cmdRefresh)
          begin
            pwrD = pdzq_pkg::ST_SELF_REFRESH;
          end
        end
      end
      pdzq_pkg::ST_POWER_DOWN, pdzq_pkg::ST_SELF_REFRESH:
      begin
        // Exit on CKE high with NOP or deselect
        if (ckeIn && cmdNop)
        begin
          pwrD = pdzq_pkg::ST_ACTIVE;
          exitPulse = 1'b1;
        end
      end
    endcase
    // Device reset pin drops every low-power state
    if (!resetN)
    begin
      pwrD = pdzq_pkg::ST_ACTIVE;
      exitPulse = 1'b0;
    end
  end

  // Register power state and its outputs
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pwrQ <= pdzq_pkg::ST_ACTIVE;
      ckePrevQ <= 1'b0;
      lowPowerQ <= 1'b0;
      selfRefreshQ <= 1'b0;
    end
    else
    begin
      pwrQ <= pwrD;
      ckePrevQ <= ckeIn;
      lowPowerQ <= (pwrD == pdzq_pkg::ST_POWER_DOWN);
      selfRefreshQ <= (pwrD == pdzq_pkg::ST_SELF_REFRESH);
    end
  end

  // Exit latencies: plain commands after one, loop-dependent after the other
  latency_timer #(.WIDTH(pdzq_pkg::CNT_W)) xpTimer (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(exitPulse),
    .loadValue(pdzq_pkg::TXP_CYC),
    .busyQ(exitBusyQ)
  );
  latency_timer #(.WIDTH(pdzq_pkg::CNT_W)) xpdllTimer (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(exitPulse),
    .loadValue(pdzq_pkg::TXPDLL_CYC),
    .busyQ(dllExitBusyQ)
  );

  // ----------------------------------------------------------------
  // Calibration engine
  // ----------------------------------------------------------------
  pdzq_pkg::cal_state_t calQ; // Engine state
  pdzq_pkg::cal_state_t calD;
  logic [pdzq_pkg::CODE_W-1:0] calCodeQ; // Working code
  logic [pdzq_pkg::CODE_W-1:0] calCodeD;
  logic [pdzq_pkg::CNT_W-1:0] calAgeQ; // Cycles since the command
  logic [pdzq_pkg::CNT_W-1:0] calAgeD;
  logic [pdzq_pkg::CNT_W-1:0] windowLenQ; // Window granted to this command
  logic [pdzq_pkg::CNT_W-1:0] windowLenD;
  logic firstLongD;
  logic calLongD;
  logic currentEnD;
  logic updateD;
  logic [pdzq_pkg::CODE_W-1:0] driverD;

  // Commands count only when awake with CKE high on both edges
  assign cmdValid = (pwrQ == pdzq_pkg::ST_ACTIVE) && ckePrevQ && ckeIn && resetN;
  assign calStart = cmdValid && cmdZq && (calQ == pdzq_pkg::CAL_IDLE);

  // Next state of the engine, one code step per running cycle
  always_comb
  begin
    calD = calQ;
    calCodeD = calCodeQ;
    calAgeD = calAgeQ;
    windowLenD = windowLenQ;
    firstLongD = firstLongPendingQ;
    calLongD = calLongQ;
    currentEnD = calCurrentEnQ;
    updateD = 1'b0;
    driverD = driverImpedanceQ;
    unique case (calQ)
      pdzq_pkg::CAL_IDLE:
      begin
        // Only an explicit command starts the engine, never a state change
        if (calStart)
        begin
          calD = pdzq_pkg::CAL_RUN;
          calAgeD = pdzq_pkg::CNT_W'(1);
          calLongD = addr10;
          currentEnD = 1'b1;
          if (addr10)
          begin
            // Long: full calibration from the midpoint
            calCodeD = pdzq_pkg::CODE_RESET;
            windowLenD = firstLongPendingQ ? pdzq_pkg::TZQINIT_CYC : pdzq_pkg::TZQOPER_CYC;
            firstLongD = 1'b0;
          end
          else
          begin
            // Short: continue from the present code
            windowLenD = pdzq_pkg::TZQCS_CYC;
          end
        end
      end
      pdzq_pkg::CAL_RUN:
      begin
        // Step toward the reference, saturating at both ends
        if (compUp && (calCodeQ != '1))
        begin
          calCodeD = calCodeQ + pdzq_pkg::CODE_W'(1);
        end
        else if (!compUp && (calCodeQ != '0))
        begin
          calCodeD = calCodeQ - pdzq_pkg::CODE_W'(1);
        end
        calAgeD = calAgeQ + pdzq_pkg::CNT_W'(1);
        // Leave the last cycle of the window for the transfer
        if (calAgeQ == windowLenQ - pdzq_pkg::CNT_W'(1))
        begin
          calD = pdzq_pkg::CAL_XFER;
        end
      end
      pdzq_pkg::CAL_XFER:
      begin
        // Hand the code to the I/O and stop the reference current
        driverD = calCodeQ;
        updateD = 1'b1;
        currentEnD = 1'b0;
        calD = pdzq_pkg::CAL_IDLE;
      end
      default:
      begin
        calD = pdzq_pkg::CAL_IDLE;
      end
    endcase
    // Device reset pin aborts calibration and rearms the init window
    if (!resetN)
    begin
      calD = pdzq_pkg::CAL_IDLE;
      currentEnD = 1'b0;
      updateD = 1'b0;
      firstLongD = 1'b1;
    end
  end

  // Register engine state and its outputs
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      calQ <= pdzq_pkg::CAL_IDLE;
      calCodeQ <= pdzq_pkg::CODE_RESET;
      calAgeQ <= '0;
      windowLenQ <= '0;
      firstLongPendingQ <= 1'b1;
      calLongQ <= 1'b0;
      calCurrentEnQ <= 1'b0;
      calBusyQ <= 1'b0;
      impedanceUpdateQ <= 1'b0;
      driverImpedanceQ <= pdzq_pkg::CODE_RESET;
    end
    else
    begin
      calQ <= calD;
      calCodeQ <= calCodeD;
      calAgeQ <= calAgeD;
      windowLenQ <= windowLenD;
      firstLongPendingQ <= firstLongD;
      calLongQ <= calLongD;
      calCurrentEnQ <= currentEnD;
      calBusyQ <= (calD != pdzq_pkg::CAL_IDLE);
      impedanceUpdateQ <= updateD;
      driverImpedanceQ <= driverD;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  lp_entry_cause_a: assert property ($rose(lowPowerQ) |-> $past(ckePrevQ && !ckeIn && cmdNop))
    else $error("Low-power entry without CKE fall and NOP");
  lp_exit_latency_a: assert property ($fell(lowPowerQ) && $past(resetN) |-> exitBusyQ && dllExitBusyQ)
    else $error("Low-power exit without exit latency");
  first_long_window_a: assert property (calStart && addr10 && firstLongPendingQ |=>
    windowLenQ == pdzq_pkg::TZQINIT_CYC && !firstLongPendingQ ##1 calBusyQ)
    else $error("First long calibration not given init window");
  update_timing_a: assert property (impedanceUpdateQ |-> calAgeQ == windowLenQ && !calBusyQ)
    else $error("Impedance update not at end of window");
  xfer_value_a: assert property (impedanceUpdateQ |-> driverImpedanceQ == $past(calCodeQ))
    else $error("Transferred code differs from engine code");
  short_window_a: assert property (calStart && !addr10 |=> ##64 impedanceUpdateQ)
    else $error("Short calibration not finished in 64 cycles");
  current_off_a: assert property (impedanceUpdateQ |-> !calCurrentEnQ ##1 !calCurrentEnQ || calBusyQ)
    else $error("Calibration current left on after transfer");
  no_self_recal_a: assert property ($fell(selfRefreshQ) |-> !calBusyQ)
    else $error("Calibration started by self-refresh exit");
  cal_start_cause_a: assert property ($rose(calBusyQ) |-> $past(cmdValid && cmdZq))
    else $error("Calibration started without a calibration command");
endmodule

// >>> ctrl_model.sv
// Controller model: drives CKE and the command pins.
// Assumes its tasks are called at the falling edge of ref_clk.
`timescale 1ns/1ns

module ctrl_model #(
  parameter int TCKE_CYC = 3,
  parameter int TXS_CYC = 8
) (
  // Clock
  input wire logic ref_clk,
  // Command bus
  output logic ckeIn,
  output logic csN,
  output logic rasN,
  output logic casN,
  output logic weN,
  output logic addr10
);
  // --------
  // Bus idle
  // --------
  // CKE high with NOP from time zero
  initial
  begin
    ckeIn = 1'h1;
    {csN, rasN, casN, weN} = 4'h7;
    addr10 = 1'h0;
  end

  // One calibration command, then NOP; no bank is ever opened
  task automatic zq(input logic a10);
    @(negedge ref_clk);
    {csN, rasN, casN, weN} = 4'h6;
    addr10 = a10;
    @(negedge ref_clk);
    {csN, rasN, casN, weN} = 4'h7;
    addr10 = ~a10;
  endtask

  // CKE low with NOP or refresh, held at least tCKE
  task automatic lowPowerEnter(input logic sr);
    @(negedge ref_clk);
    ckeIn = 1'h0;
    {csN, rasN, casN, weN} = sr ? 4'h1 : 4'h7;
    @(negedge ref_clk);
    {csN, rasN, casN, weN} = 4'hF;
    repeat (TCKE_CYC) @(negedge ref_clk);
  endtask

  // CKE high with NOP
  task automatic lowPowerExit();
    @(negedge ref_clk);
    ckeIn = 1'h1;
    {csN, rasN, casN, weN} = 4'h7;
    @(negedge ref_clk);
  endtask

  // NOP only until exit, refresh and lock windows have passed
  task automatic settle();
    repeat (TXS_CYC) @(negedge ref_clk);
  endtask
endmodule

// >>> testbench.sv
// Self-checking bench for power_down_zq_calibration.
// Assumes ctrl_model drives the command bus; the bench owns resets and compUp.
`timescale 1ns/1ns

`define CHK(nm, e, g) testsRun++; if ((g) !== (e)) begin $display("[ERR] %s exp %0h got %0h", nm, e, g); numErrors++; end

module testbench;
  // Clock, resets, comparator
  logic ref_clk;
  logic rst;
  logic resetN;
  logic compUp;
  // Command bus
  logic ckeIn, csN, rasN, casN, weN, addr10;
  // Device status
  logic lowPowerQ, selfRefreshQ, exitBusyQ, dllExitBusyQ;
  logic calBusyQ, calLongQ, calCurrentEnQ, firstLongPendingQ, impedanceUpdateQ;
  logic [pdzq_pkg::CODE_W-1:0] driverImpedanceQ;
  // Bookkeeping
  int numErrors = 0;
  int testsRun = 0;
  int cycles = 0;

  // ---------
  // Instances
  // ---------
  power_down_zq_calibration power_down_zq_calibration_i (
    .ref_clk(ref_clk), .rst(rst), .ckeIn(ckeIn), .csN(csN), .rasN(rasN), .casN(casN),
    .weN(weN), .addr10(addr10), .resetN(resetN), .compUp(compUp),
    .lowPowerQ(lowPowerQ), .selfRefreshQ(selfRefreshQ), .exitBusyQ(exitBusyQ),
    .dllExitBusyQ(dllExitBusyQ), .calBusyQ(calBusyQ), .calLongQ(calLongQ),
    .calCurrentEnQ(calCurrentEnQ), .firstLongPendingQ(firstLongPendingQ),
    .impedanceUpdateQ(impedanceUpdateQ), .driverImpedanceQ(driverImpedanceQ)
  );
  ctrl_model ctrl_model_i (
    .ref_clk(ref_clk), .ckeIn(ckeIn), .csN(csN), .rasN(rasN), .casN(casN),
    .weN(weN), .addr10(addr10)
  );

  // 100 MHz clock
  initial
  begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Hang guard, about twice the expected run
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      numErrors++;
      endSim();
    end
  end

  // Counts, verdict, stop
  task automatic endSim();
    $display("checks %0d errors %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ---------
  // Scenarios
  // ---------
  // Calibrate; check window length, code hold and transferred code
  task automatic zqRun(input logic a10, input int win, input logic [5:0] prev, input logic [5:0] code,
                       input logic dup);
    int n;
    n = 0;
    ctrl_model_i.zq(a10);
    `CHK("calBusyQ", 1'h1, calBusyQ)
    `CHK("calCurrentEnQ", 1'h1, calCurrentEnQ)
    while (impedanceUpdateQ !== 1'h1 && n < 1000)
    begin
      // Optional second command while busy must be ignored
      if (dup && n == 10)
      begin
        ctrl_model_i.zq(~a10);
        n += 2;
      end
      else
      begin
        @(negedge ref_clk);
        n++;
      end
      if (n == 20)
      begin
        `CHK("midCode", prev, driverImpedanceQ)
      end
    end
    `CHK("window", win, n)
    `CHK("code", code, driverImpedanceQ)
    `CHK("calLongQ", a10, calLongQ)
    `CHK("calCurrentEnQ", 1'h0, calCurrentEnQ)
    `CHK("calBusyQ", 1'h0, calBusyQ)
    @(negedge ref_clk);
    `CHK("pulse", 1'h0, impedanceUpdateQ)
  endtask

  // Values after reset
  task automatic checkReset();
    `CHK("firstLongPendingQ", 1'h1, firstLongPendingQ)
    `CHK("code", 6'h20, driverImpedanceQ)
    `CHK("calCurrentEnQ", 1'h0, calCurrentEnQ)
  endtask

  // First long, later long with ignored short, then short
  task automatic longShort();
    zqRun(1'h1, 512, 6'h20, 6'h3F, 1'h0);
    `CHK("firstLongPendingQ", 1'h0, firstLongPendingQ)
    compUp = 1'h0;
    zqRun(1'h1, 256, 6'h3F, 6'h00, 1'h1);
    compUp = 1'h1;
    zqRun(1'h0, 64, 6'h00, 6'h3F, 1'h0);
  endtask

  // Power-down entry and exit latencies
  task automatic powerDown();
    ctrl_model_i.lowPowerEnter(1'h0);
    `CHK("lowPowerQ", 1'h1, lowPowerQ)
    // A calibration pattern while asleep is a don't-care and must start nothing
    ctrl_model_i.zq(1'h0);
    `CHK("calBusyQ", 1'h0, calBusyQ)
    `CHK("lowPowerQ", 1'h1, lowPowerQ)
    ctrl_model_i.lowPowerExit();
    `CHK("lowPowerQ", 1'h0, lowPowerQ)
    `CHK("dllExitBusyQ", 1'h1, dllExitBusyQ)
    repeat (2) @(negedge ref_clk);
    `CHK("exitBusyQ", 1'h1, exitBusyQ)
    @(negedge ref_clk);
    `CHK("exitBusyQ", 1'h0, exitBusyQ)
    `CHK("dllExitBusyQ", 1'h0, dllExitBusyQ)
    ctrl_model_i.settle();
  endtask

  // Self-refresh exit brings no calibration until one is commanded
  task automatic selfRefresh();
    compUp = 1'h0;
    ctrl_model_i.lowPowerEnter(1'h1);
    `CHK("selfRefreshQ", 1'h1, selfRefreshQ)
    ctrl_model_i.lowPowerExit();
    `CHK("selfRefreshQ", 1'h0, selfRefreshQ)
    ctrl_model_i.settle();
    `CHK("calBusyQ", 1'h0, calBusyQ)
    `CHK("code", 6'h3F, driverImpedanceQ)
    zqRun(1'h0, 64, 6'h3F, 6'h00, 1'h0);
  endtask

  // Device reset aborts a long run; next long gets the init window
  task automatic resetAbort();
    compUp = 1'h1;
    ctrl_model_i.zq(1'h1);
    repeat (20) @(negedge ref_clk);
    resetN = 1'h0;
    @(negedge ref_clk);
    resetN = 1'h1;
    `CHK("calBusyQ", 1'h0, calBusyQ)
    `CHK("firstLongPendingQ", 1'h1, firstLongPendingQ)
    repeat (300) @(negedge ref_clk);
    `CHK("code", 6'h00, driverImpedanceQ)
    zqRun(1'h1, 512, 6'h00, 6'h3F, 1'h0);
  endtask

  // Main sequence
  initial
  begin
    rst = 1'h1;
    resetN = 1'h1;
    compUp = 1'h1;
    repeat (20) @(negedge ref_clk);
    rst = 1'h0;
    repeat (2) @(negedge ref_clk);
    checkReset();
    longShort();
    powerDown();
    selfRefresh();
    resetAbort();
    endSim();
  end
endmodule
